// [design/cfm_flag_unit.sv]
// condition flags, interrupt mask sequencing, standby and break handling
//
// The address map and the Wishbone register port were decided locally.
`timescale 1ns/1ps
`include "cfm_regs.svh"

// How it works
// - flag bits 6 and 5 always read as one.
// - overflow flag follows two's complement overflow of the result.
// - add and add-with-carry set half-carry on carry from bit 3 to 4.
// - decimal adjust derives its correction from half-carry, carry and the accumulator value.
// - mask set blocks all maskable requests; clear lets them in.
// - interrupt entry pushes registers, then sets mask, then fetches vector.
// - entry never stacks the upper index byte; software saves it.
// - with several requests pending the highest priority one goes first.
// - return from interrupt pulls registers and the stacked mask.
// - reset sets the mask; the clear-mask, wait and stop ops clear it, and the return pull restores it.
// - negative flag copies result bit 7.
// - zero flag is one when the 8-bit result is zero.
// - carry from addition; shifts also update carry.
// - wait clears mask, stops core clock; irq wake restarts the clock and entry then sets the mask.
// - stop clears mask, stops core clock; external irq wakes.
// - after stop the core clock waits out the oscillator delay.
// - enabled break finishes current op then runs software interrupt.
// - break vector is FFFC, or FEFC in monitor mode.
// - return inside break routine ends break once request is gone.
// - stack immediate add adds signed byte to stack pointer, no flags.
// - index immediate add adds signed byte to index, no flags.
// - branch on carry clear jumps to pc plus 2 plus offset.
module cfm_flag_unit #(
  parameter int NIRQ      = 4,
  parameter int OSC_DELAY = 4096,
  parameter int STK_AW    = 8
) (
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [7:0]         wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [31:0]        wb_dat_i,
  output logic      [31:0]        wb_dat_o,
  output logic                    wb_ack_o,
  input  wire logic               op_valid_i,
  input  wire logic [7:0]         op_code_i,
  input  wire logic [7:0]         op_data_i,
  output logic                    op_ready_o,
  input  wire logic [NIRQ-1:0]    irq_pin_i,
  input  wire logic               brk_req_i,
  input  wire logic [15:0]        vect_data_i,
  output logic                    vect_fetch_o,
  output logic      [15:0]        vect_addr_o,
  output logic                    core_clk_en_o,
  output cfm_pkg::cfm_flags_s     flags_o
);
  // ==========================================================
  // state
  cfm_pkg::cfm_state_e state_reg;
  cfm_pkg::cfm_flags_s flags_reg;
  cfm_pkg::cfm_alu_s   alu;
  logic [7:0]          acc_reg;
  logic [15:0]         sp_reg;
  logic [15:0]         ix_reg;
  logic [15:0]         pc_reg;
  logic [1:0]          ctrl_reg;
  logic [2:0]          cnt_reg;
  logic [1:0]          busy_reg;
  logic                ready_reg;
  logic                brk_act_reg;
  logic                clk_en_reg;
  logic                fetch_reg;
  logic [15:0]         vec_reg;
  logic [31:0]         stab_reg;
  logic [31:0]         rdat_reg;
  logic                ack_reg;
  logic [NIRQ-1:0]     s1_reg;
  logic [NIRQ-1:0]     s2_reg;
  logic [NIRQ-1:0]     s3_reg;
  logic [NIRQ-1:0]     pend_reg;
  logic [7:0]          stack_mem [0:(1<<STK_AW)-1];
  logic                accept;
  logic                wr_hit;
  logic                brk_take;
  logic                irq_take;
  logic [7:0]          push_byte;
  logic [7:0]          pop_byte;
  logic [15:0]         rel_ext;

  // ==========================================================
  // helpers
  // lowest index is the highest priority request
  function automatic logic [15:0] irq_vector(input logic [NIRQ-1:0] p);
    logic [15:0] v;
    v = `CFM_VEC_IRQ;
    for (int k = NIRQ - 1; k >= 0; k--) begin
      if (p[k]) begin
        v = `CFM_VEC_IRQ - 16'(2 * k);
      end
    end
    return v;
  endfunction

  function automatic logic [1:0] op_cycles(input logic [7:0] op);
    return (op == `CFM_OP_BCC) ? `CFM_CYC_BCC : `CFM_CYC_IMM;
  endfunction

  // ASLA, DAA and CLI are one byte long; every other op, inherent RTI, SWI, WAIT and STOP included, counts two
  function automatic logic [15:0] op_len(input logic [7:0] op);
    logic inh;
    inh = (op == `CFM_OP_ASLA) || (op == `CFM_OP_DAA) || (op == `CFM_OP_CLI);
    return inh ? 16'h0001 : 16'h0002;
  endfunction

  assign accept   = (state_reg == cfm_pkg::ST_RUN) && ready_reg && op_valid_i;
  assign wr_hit   = wb_cyc_i && wb_stb_i && wb_we_i && ack_reg;
  assign brk_take = ctrl_reg[`CFM_CTRL_BRKEN] && brk_req_i && !brk_act_reg;
  assign irq_take = !flags_reg.i && (|pend_reg);
  assign rel_ext  = {{8{op_data_i[7]}}, op_data_i};
  assign pop_byte = stack_mem[STK_AW'(sp_reg + 16'h0001)];

  // stacked frame: pcl, pch, x, a, flags; upper index byte is left alone
  always_comb begin
    case (cnt_reg)
      3'h0:    push_byte = pc_reg[7:0];
      3'h1:    push_byte = pc_reg[15:8];
      3'h2:    push_byte = ix_reg[7:0];
      3'h3:    push_byte = acc_reg;
      default: push_byte = flags_reg;
    endcase
  end

  // ==========================================================
  // operation results and their flags
  always_comb begin
    logic [8:0] sum;
    logic [4:0] low;
    logic [7:0] corr;
    logic       cin;
    sum  = 9'h000;
    low  = 5'h00;
    corr = 8'h00;
    cin  = 1'b0;
    alu.f      = flags_reg;
    alu.res    = acc_reg;
    alu.wr_acc = 1'b0;
    case (op_code_i)
      `CFM_OP_ADC, `CFM_OP_ADD: begin
        cin = (op_code_i == `CFM_OP_ADC) ? flags_reg.c : 1'b0;
        sum = {1'b0, acc_reg} + {1'b0, op_data_i} + {8'h00, cin};
        low = {1'b0, acc_reg[3:0]} + {1'b0, op_data_i[3:0]} + {4'h0, cin};
        alu.res = sum[7:0];
        alu.f.c = sum[8];
        alu.f.h = low[4];
        alu.f.v = (acc_reg[7] == op_data_i[7]) && (sum[7] != acc_reg[7]);
        alu.wr_acc = 1'b1;
      end
      `CFM_OP_AND: begin
        alu.res = acc_reg & op_data_i;
        alu.f.v = 1'b0;
        alu.wr_acc = 1'b1;
      end
      `CFM_OP_ASLA: begin
        alu.res = {acc_reg[6:0], 1'b0};
        alu.f.c = acc_reg[7];
        alu.f.v = acc_reg[7] ^ acc_reg[6];
        alu.wr_acc = 1'b1;
      end
      `CFM_OP_DAA: begin
        // correction taken from the half-carry and carry states and the accumulator value
        if (flags_reg.h || (acc_reg[3:0] > 4'h9)) begin
          corr[3:0] = 4'h6;
        end
        if (flags_reg.c || (acc_reg > 8'h99)) begin
          corr[7:4] = 4'h6;
        end
        alu.res = acc_reg + corr;
        alu.f.c = corr[7:4] != 4'h0;
        alu.wr_acc = 1'b1;
      end
      default: alu.wr_acc = 1'b0;
    endcase
    if (alu.wr_acc) begin
      alu.f.n = alu.res[7];
      alu.f.z = alu.res == 8'h00;
    end
  end

  // ==========================================================
  // pin synchroniser: a level counts once stages two and three agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_reg   <= '0;
      s2_reg   <= '0;
      s3_reg   <= '0;
      pend_reg <= '0;
    end else begin
      s1_reg <= irq_pin_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      for (int k = 0; k < NIRQ; k++) begin
        if (s2_reg[k] == s3_reg[k]) begin
          pend_reg[k] <= s3_reg[k];
        end
      end
    end
  end

  // ==========================================================
  // wishbone slave: ack one cycle after the strobe, writes land on the ack edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg  <= 1'b0;
      rdat_reg <= 32'h0000_0000;
      ctrl_reg <= 2'h0;
    end else begin
      ack_reg <= wb_cyc_i && wb_stb_i && !ack_reg;
      if (wb_cyc_i && wb_stb_i && !ack_reg) begin
        case (wb_adr_i)
          `CFM_OFF_FLAGS:  rdat_reg <= {24'h000000, flags_reg};
          `CFM_OFF_ACC:    rdat_reg <= {24'h000000, acc_reg};
          `CFM_OFF_SP:     rdat_reg <= {16'h0000, sp_reg};
          `CFM_OFF_INDEX:  rdat_reg <= {16'h0000, ix_reg};
          `CFM_OFF_PC:     rdat_reg <= {16'h0000, pc_reg};
          `CFM_OFF_CTRL:   rdat_reg <= {30'h00000000, ctrl_reg};
          `CFM_OFF_STATUS: rdat_reg <= {24'h000000, clk_en_reg, brk_act_reg, 3'h0, state_reg};
          default:         rdat_reg <= 32'h0000_0000;
        endcase
      end
      if (wr_hit && (wb_adr_i == `CFM_OFF_CTRL) && wb_sel_i[0]) begin
        ctrl_reg <= wb_dat_i[1:0];
      end
    end
  end

  // ==========================================================
  // sequencer: op boundary, interrupt entry, return, standby
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg   <= cfm_pkg::ST_RUN;
      cnt_reg     <= 3'h0;
      busy_reg    <= 2'h0;
      ready_reg   <= 1'b0;
      brk_act_reg <= 1'b0;
      clk_en_reg  <= 1'b1;
      fetch_reg   <= 1'b0;
      vec_reg     <= `CFM_VEC_SWI;
      stab_reg    <= 32'h0000_0000;
    end else begin
      fetch_reg <= 1'b0;
      case (state_reg)
        cfm_pkg::ST_RUN: begin
          if (accept) begin
            ready_reg <= 1'b0;
            busy_reg  <= op_cycles(op_code_i) - `CFM_CYC_IMM;
            case (op_code_i)
              `CFM_OP_SWI: begin
                state_reg <= cfm_pkg::ST_PUSH;
                vec_reg   <= `CFM_VEC_SWI;
              end
              `CFM_OP_RTI: begin
                state_reg <= cfm_pkg::ST_PULL;
                if (brk_act_reg && !brk_req_i) begin
                  brk_act_reg <= 1'b0;
                end
              end
              `CFM_OP_WAIT: begin
                state_reg  <= cfm_pkg::ST_WAIT;
                clk_en_reg <= 1'b0;
              end
              `CFM_OP_STOP: begin
                state_reg  <= cfm_pkg::ST_STOP;
                clk_en_reg <= 1'b0;
              end
              default: state_reg <= cfm_pkg::ST_RUN;
            endcase
          end else if (ready_reg && (brk_take || irq_take)) begin
            ready_reg <= 1'b0;
          end else if (!ready_reg && (busy_reg == 2'h0)) begin
            // break outranks maskable requests at an op boundary
            if (brk_take) begin
              state_reg   <= cfm_pkg::ST_PUSH;
              brk_act_reg <= 1'b1;
              vec_reg     <= ctrl_reg[`CFM_CTRL_MON] ? `CFM_VEC_SWI_MN : `CFM_VEC_SWI;
            end else if (irq_take) begin
              state_reg <= cfm_pkg::ST_PUSH;
              vec_reg   <= irq_vector(pend_reg);
            end else begin
              ready_reg <= 1'b1;
            end
          end else if (busy_reg != 2'h0) begin
            busy_reg <= busy_reg - 2'h1;
          end
        end
        cfm_pkg::ST_PUSH: begin
          cnt_reg <= (cnt_reg == `CFM_FRAME_LAST) ? 3'h0 : cnt_reg + 3'h1;
          if (cnt_reg == `CFM_FRAME_LAST) begin
            state_reg <= cfm_pkg::ST_MASK;
          end
        end
        cfm_pkg::ST_MASK: begin
          state_reg <= cfm_pkg::ST_VECT;
          fetch_reg <= 1'b1;
        end
        cfm_pkg::ST_VECT: state_reg <= cfm_pkg::ST_RUN;
        cfm_pkg::ST_PULL: begin
          cnt_reg <= (cnt_reg == `CFM_FRAME_LAST) ? 3'h0 : cnt_reg + 3'h1;
          if (cnt_reg == `CFM_FRAME_LAST) begin
            state_reg <= cfm_pkg::ST_RUN;
          end
        end
        cfm_pkg::ST_WAIT: begin
          // any request wakes; the mask stays clear until entry sets it
          if (|pend_reg) begin
            state_reg  <= cfm_pkg::ST_PUSH;
            vec_reg    <= irq_vector(pend_reg);
            clk_en_reg <= 1'b1;
          end
        end
        cfm_pkg::ST_STOP: begin
          if (pend_reg[0]) begin
            state_reg <= cfm_pkg::ST_STAB;
            stab_reg  <= 32'(OSC_DELAY - 1);
          end
        end
        cfm_pkg::ST_STAB: begin
          if (stab_reg == 32'h0000_0000) begin
            state_reg  <= cfm_pkg::ST_PUSH;
            vec_reg    <= `CFM_VEC_IRQ;
            clk_en_reg <= 1'b1;
          end else begin
            stab_reg <= stab_reg - 32'h0000_0001;
          end
        end
        default: state_reg <= cfm_pkg::ST_RUN;
      endcase
    end
  end

  // ==========================================================
  // condition flags; a hardware update wins over a bus write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_reg <= `CFM_FLAGS_RST;
    end else begin
      if (accept) begin
        flags_reg <= alu.f;
        if ((op_code_i == `CFM_OP_CLI) || (op_code_i == `CFM_OP_WAIT)
            || (op_code_i == `CFM_OP_STOP)) begin
          flags_reg.i <= 1'b0;
        end
      end else if (state_reg == cfm_pkg::ST_MASK) begin
        flags_reg.i <= 1'b1;
      end else if ((state_reg == cfm_pkg::ST_PULL) && (cnt_reg == 3'h0)) begin
        flags_reg <= pop_byte;
      end else if (wr_hit && (wb_adr_i == `CFM_OFF_FLAGS) && wb_sel_i[0]) begin
        // software may set the mask here but never clear it
        flags_reg   <= wb_dat_i[7:0];
        flags_reg.i <= wb_dat_i[3] | flags_reg.i;
      end
      flags_reg.one6 <= 1'b1;
      flags_reg.one5 <= 1'b1;
    end
  end

  // ==========================================================
  // accumulator, pointers, program counter and stack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc_reg <= 8'h00;
      sp_reg  <= `CFM_SP_RST;
      ix_reg  <= 16'h0000;
      pc_reg  <= 16'h0000;
    end else if (accept) begin
      pc_reg <= pc_reg + op_len(op_code_i);
      if (alu.wr_acc) begin
        acc_reg <= alu.res;
      end
      if (op_code_i == `CFM_OP_AIS) begin
        sp_reg <= sp_reg + rel_ext;
      end
      if (op_code_i == `CFM_OP_AIX) begin
        ix_reg <= ix_reg + rel_ext;
      end
      if ((op_code_i == `CFM_OP_BCC) && !flags_reg.c) begin
        pc_reg <= pc_reg + 16'h0002 + rel_ext;
      end
    end else if (state_reg == cfm_pkg::ST_PUSH) begin
      stack_mem[STK_AW'(sp_reg)] <= push_byte;
      sp_reg <= sp_reg - 16'h0001;
    end else if (state_reg == cfm_pkg::ST_VECT) begin
      pc_reg <= vect_data_i;
    end else if (state_reg == cfm_pkg::ST_PULL) begin
      sp_reg <= sp_reg + 16'h0001;
      case (cnt_reg)
        3'h1:    acc_reg        <= pop_byte;
        3'h2:    ix_reg[7:0]    <= pop_byte;
        3'h3:    pc_reg[15:8]   <= pop_byte;
        3'h4:    pc_reg[7:0]    <= pop_byte;
        default: acc_reg        <= acc_reg;
      endcase
    end else if (wr_hit) begin
      case (wb_adr_i)
        `CFM_OFF_ACC:   acc_reg <= wb_dat_i[7:0];
        `CFM_OFF_SP:    sp_reg  <= wb_dat_i[15:0];
        `CFM_OFF_INDEX: ix_reg  <= wb_dat_i[15:0];
        `CFM_OFF_PC:    pc_reg  <= wb_dat_i[15:0];
        default:        acc_reg <= acc_reg;
      endcase
    end
  end

  assign wb_dat_o      = rdat_reg;
  assign wb_ack_o      = ack_reg;
  assign op_ready_o    = ready_reg;
  assign vect_fetch_o  = fetch_reg;
  assign vect_addr_o   = vec_reg;
  assign core_clk_en_o = clk_en_reg;
  assign flags_o       = flags_reg;

  // ==========================================================
  // assertions
  sequence s_push_frame;
    (state_reg == cfm_pkg::ST_PUSH) [*5];
  endsequence
  sequence s_mask_then_vect;
    (state_reg == cfm_pkg::ST_MASK) ##1 (state_reg == cfm_pkg::ST_VECT) && flags_reg.i;
  endsequence

  a_fixed_ones: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(wr_hit) |-> flags_reg[6:5] == 2'b11) else $error("fixed flag bits not one");
  a_add_overflow: assert property (@(posedge clk_i) disable iff (rst_i)
    accept && (op_code_i == `CFM_OP_ADD) |=> flags_reg.v ==
      (($past(acc_reg[7]) == $past(op_data_i[7])) && (acc_reg[7] != $past(acc_reg[7]))))
    else $error("overflow flag wrong after add");
  a_half_carry: assert property (@(posedge clk_i) disable iff (rst_i)
    accept && (op_code_i == `CFM_OP_ADD) |=> flags_reg.h ==
      (({1'b0, $past(acc_reg[3:0])} + {1'b0, $past(op_data_i[3:0])}) > 5'h0F))
    else $error("half carry wrong after add");
  a_mask_blocks: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_reg == cfm_pkg::ST_RUN) && flags_reg.i && !brk_take && !accept
      |=> state_reg != cfm_pkg::ST_PUSH) else $error("masked request entered");
  a_entry_order: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(state_reg == cfm_pkg::ST_PUSH) |-> s_push_frame ##1 s_mask_then_vect)
    else $error("entry sequence out of order");
  a_reset_mask: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(rst_i) |-> flags_reg.i) else $error("mask not set after reset");
  a_mask_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(flags_reg.i) |-> $past(accept) || $past(state_reg == cfm_pkg::ST_PULL))
    else $error("mask cleared without cause");
  a_zero_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    accept && (op_code_i == `CFM_OP_AND) |=> flags_reg.z == (acc_reg == 8'h00))
    else $error("zero flag wrong");
  a_stab_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_reg == cfm_pkg::ST_STAB) |-> !core_clk_en_o) else $error("clock ran early");
  a_imm_flags: assert property (@(posedge clk_i) disable iff (rst_i)
    accept && ((op_code_i == `CFM_OP_AIX) || (op_code_i == `CFM_OP_AIS))
      |=> flags_reg == $past(flags_reg)) else $error("immediate add changed flags");
  a_bcc_target: assert property (@(posedge clk_i) disable iff (rst_i)
    accept && (op_code_i == `CFM_OP_BCC) && !flags_reg.c
      |=> pc_reg == $past(pc_reg) + 16'h0002 + $past(rel_ext)) else $error("bad branch");
endmodule

// [design/cfm_regs.svh]
// register offsets, reset values, opcodes and vectors of the flag and mask unit
`ifndef CFM_REGS_SVH
`define CFM_REGS_SVH
// ==========================================================
// register byte offsets
`define CFM_OFF_FLAGS  8'h00
`define CFM_OFF_ACC    8'h04
`define CFM_OFF_SP     8'h08
`define CFM_OFF_INDEX  8'h0C
`define CFM_OFF_PC     8'h10
`define CFM_OFF_CTRL   8'h14
`define CFM_OFF_STATUS 8'h18
// ==========================================================
// reset values and fixed fields
`define CFM_FLAGS_RST  8'h68
`define CFM_SP_RST     16'h00FF
`define CFM_CTRL_BRKEN 0
`define CFM_CTRL_MON   1
// ==========================================================
// opcodes handled here
`define CFM_OP_ADC     8'hA9
`define CFM_OP_ADD     8'hAB
`define CFM_OP_AND     8'hA4
`define CFM_OP_ASLA    8'h48
`define CFM_OP_AIS     8'hA7
`define CFM_OP_AIX     8'hAF
`define CFM_OP_BCC     8'h24
`define CFM_OP_DAA     8'h72
`define CFM_OP_CLI     8'h9A
`define CFM_OP_RTI     8'h80
`define CFM_OP_SWI     8'h83
`define CFM_OP_WAIT    8'h8F
`define CFM_OP_STOP    8'h8E
// ==========================================================
// cycle counts and stack frame
`define CFM_CYC_IMM    2'h2
`define CFM_CYC_BCC    2'h3
`define CFM_FRAME_LAST 3'h4
// ==========================================================
// vectors
`define CFM_VEC_SWI    16'hFFFC
`define CFM_VEC_SWI_MN 16'hFEFC
`define CFM_VEC_IRQ    16'hFFFA
`endif

// [design/cfm_pkg.sv]
// types shared by the flag and mask unit
package cfm_pkg;
  // ==========================================================
  // condition flags, bit 7 down to bit 0
  typedef struct packed {
    logic v;
    logic one6;
    logic one5;
    logic h;
    logic i;
    logic n;
    logic z;
    logic c;
  } cfm_flags_s;

  // result of one flag-setting operation
  typedef struct packed {
    logic [7:0] res;
    cfm_flags_s f;
    logic       wr_acc;
  } cfm_alu_s;

  typedef enum logic [2:0] {
    ST_RUN  = 3'b000,
    ST_PUSH = 3'b001,
    ST_MASK = 3'b010,
    ST_VECT = 3'b011,
    ST_PULL = 3'b100,
    ST_WAIT = 3'b101,
    ST_STOP = 3'b110,
    ST_STAB = 3'b111
  } cfm_state_e;
endpackage

// [verification/cfm_prog_mem.sv]
// program memory model that answers vector fetches of the flag and mask unit
`timescale 1ns/1ps
module cfm_prog_mem (
  input  wire logic        clk_i,
  input  wire logic        vect_fetch_i,
  input  wire logic [15:0] vect_addr_i,
  output logic      [15:0] vect_data_o
);
  logic [15:0] idle_reg = 16'h5A5A;
  // ==========================================================
  // outside a fetch the bus toggles every cycle so stale data can never
  // pass for a real read
  always @(posedge clk_i) begin
    idle_reg <= ~idle_reg;
  end
  // each vector holds the inverse of its own address; the answer stands
  // within the fetch cycle, since the unit loads it at the edge ending the pulse
  assign vect_data_o = vect_fetch_i ? ~vect_addr_i : idle_reg;
endmodule

// [verification/testbench.sv]
// self-checking bench for the flag and mask unit
`timescale 1ns/1ps
`include "cfm_regs.svh"
module testbench;
  logic                clk_i = 1'b0;
  logic                rst_i = 1'b1;
  logic                cyc   = 1'b0;
  logic                we    = 1'b0;
  logic [7:0]          adr   = 8'h00;
  logic [31:0]         wdat  = 32'h0;
  logic [31:0]         rdat, dat_o, p;
  logic                ack, rdy, fetch, clk_en;
  logic                opv   = 1'b0;
  logic [7:0]          code  = 8'h00;
  logic [7:0]          odat  = 8'h00;
  logic [3:0]          irq   = 4'h0;
  logic                brk   = 1'b0;
  logic [15:0]         vdat, vadr;
  cfm_pkg::cfm_flags_s flags;
  int                  mismatches  = 0;
  int                  checks_done = 0;
  // ==========================================================
  // clock, design and program memory
  always #50 clk_i = ~clk_i;
  cfm_flag_unit #(.NIRQ(4), .OSC_DELAY(4), .STK_AW(8)) i_cfm_flag_unit (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .op_valid_i(opv), .op_code_i(code), .op_data_i(odat), .op_ready_o(rdy),
    .irq_pin_i(irq), .brk_req_i(brk), .vect_data_i(vdat), .vect_fetch_o(fetch),
    .vect_addr_o(vadr), .core_clk_en_o(clk_en), .flags_o(flags));
  cfm_prog_mem i_cfm_prog_mem (.clk_i(clk_i), .vect_fetch_i(fetch), .vect_addr_i(vadr),
    .vect_data_o(vdat));
  // ==========================================================
  // shared tasks
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // classic cycle: hold until ack is sampled, take data at that edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin @(posedge clk_i); n++; end while (ack !== 1'b1 && n < 50);
    rdat = dat_o;
    cyc <= 1'b0;
    @(posedge clk_i);
    if (n >= 50) mismatches++;
  endtask
  // bounded waits; stop recovery and standby make these the long ones
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin @(posedge clk_i); n++; end while (rdy !== 1'b1 && n < 500);
    if (n >= 500) mismatches++;
  endtask
  task automatic wait_fetch;
    int n;
    n = 0;
    do begin @(posedge clk_i); n++; end while (fetch !== 1'b1 && n < 500);
    if (n >= 500) mismatches++;
  endtask
  task automatic op(input logic [7:0] c, input logic [7:0] d);
    wait_rdy;
    opv <= 1'b1;
    code <= c;
    odat <= d;
    @(posedge clk_i);
    opv <= 1'b0;
  endtask
  task automatic op_flags(input logic [7:0] c, input logic [7:0] d, input logic [7:0] e);
    op(c, d);
    wait_rdy;
    cmp("flags", {24'h0, e}, {24'h0, flags});
  endtask
  // ==========================================================
  // scenarios
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    bus(1'b1, `CFM_OFF_FLAGS, 32'h0);
    bus(1'b0, `CFM_OFF_FLAGS, 32'h0);
    cmp("flags read", 32'h68, rdat);
    bus(1'b0, `CFM_OFF_SP, 32'h0);
    cmp("sp", 32'h00FF, rdat);
    bus(1'b0, 8'h40, 32'h0);
    cmp("unmapped", 32'h0, rdat);
    bus(1'b1, `CFM_OFF_ACC, 32'h7F);
    op_flags(`CFM_OP_ADD, 8'h01, 8'hFC);
    op_flags(`CFM_OP_ADC, 8'h80, 8'hEB);
    op_flags(`CFM_OP_ADC, 8'h00, 8'h68);
    bus(1'b0, `CFM_OFF_ACC, 32'h0);
    cmp("acc", 32'h01, rdat);
    op_flags(`CFM_OP_AND, 8'h00, 8'h6A);
    op_flags(`CFM_OP_ADD, 8'h09, 8'h68);
    op_flags(`CFM_OP_ADD, 8'h09, 8'h78);
    op_flags(`CFM_OP_DAA, 8'h00, 8'h78);
    bus(1'b0, `CFM_OFF_ACC, 32'h0);
    cmp("bcd acc", 32'h18, rdat);
    op_flags(`CFM_OP_ADD, 8'h90, 8'h6C);
    op_flags(`CFM_OP_DAA, 8'h00, 8'h69);
    op_flags(`CFM_OP_ASLA, 8'h00, 8'h68);
    op_flags(`CFM_OP_AIS, 8'hFF, 8'h68);
    bus(1'b0, `CFM_OFF_SP, 32'h0);
    cmp("sp", 32'h00FE, rdat);
    op_flags(`CFM_OP_AIX, 8'h80, 8'h68);
    bus(1'b0, `CFM_OFF_INDEX, 32'h0);
    cmp("index", 32'hFF80, rdat);
    bus(1'b0, `CFM_OFF_PC, 32'h0);
    p = rdat;
    op_flags(`CFM_OP_BCC, 8'h10, 8'h68);
    bus(1'b0, `CFM_OFF_PC, 32'h0);
    cmp("pc", p + 32'h12, rdat);
    // a masked request must leave the op port alone
    irq <= 4'h8;
    repeat (12) @(posedge clk_i);
    cmp("ready", 32'h1, {31'h0, rdy});
    irq <= 4'h0;
    repeat (6) @(posedge clk_i); // let the request drain from the pin filter first
    op_flags(`CFM_OP_CLI, 8'h00, 8'h60);
    bus(1'b0, `CFM_OFF_PC, 32'h0);
    p = rdat;
    irq <= 4'h6;
    wait_fetch;
    cmp("vector", 32'hFFF8, {16'h0, vadr});
    cmp("mask at fetch", 32'h1, {31'h0, flags.i});
    irq <= 4'h0;
    wait_rdy;
    bus(1'b0, `CFM_OFF_PC, 32'h0);
    cmp("pc", 32'h0007, rdat);
    op_flags(`CFM_OP_RTI, 8'h00, 8'h60);
    bus(1'b0, `CFM_OFF_PC, 32'h0);
    cmp("pc", p, rdat);
    // both standby kinds, woken by the external request
    for (int k = 0; k < 2; k++) begin
      op(k == 0 ? `CFM_OP_WAIT : `CFM_OP_STOP, 8'h00);
      repeat (4) @(posedge clk_i);
      cmp("clk_en", 32'h0, {31'h0, clk_en});
      cmp("mask", 32'h0, {31'h0, flags.i});
      irq <= 4'h1;
      wait_fetch;
      cmp("vector", 32'hFFFA, {16'h0, vadr});
      irq <= 4'h0;
      op_flags(`CFM_OP_RTI, 8'h00, 8'h60);
    end
    // software interrupt opcode uses the normal vector
    op(`CFM_OP_SWI, 8'h00);
    wait_fetch;
    cmp("swi vector", 32'hFFFC, {16'h0, vadr});
    op_flags(`CFM_OP_RTI, 8'h00, 8'h60);
    // break in normal then monitor mode, released before the return
    for (int k = 0; k < 2; k++) begin
      bus(1'b1, `CFM_OFF_CTRL, k == 0 ? 32'h1 : 32'h3);
      brk <= 1'b1;
      wait_fetch;
      cmp("break vector", k == 0 ? 32'hFFFC : 32'hFEFC, {16'h0, vadr});
      brk <= 1'b0;
      op(`CFM_OP_RTI, 8'h00);
      wait_rdy;
      bus(1'b0, `CFM_OFF_STATUS, 32'h0);
      cmp("break active", 32'h0, {31'h0, rdat[6]});
    end
    // reset in mid-run ends wait with the mask set again
    op(`CFM_OP_WAIT, 8'h00);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    cmp("mask after reset", 32'h1, {31'h0, flags.i});
    cmp("clk_en after reset", 32'h1, {31'h0, clk_en});
    test_done;
  end
  // watchdog: the whole sequence needs a few hundred cycles, far below the 20000-cycle limit
  initial begin
    #(100 * 20000);
    mismatches++;
    test_done;
  end
endmodule
